// File: design/dcc_pkg.sv
// Package of register map, field positions, reset values and carrier types for the DMA channel control block.
package dcc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets on the plain register port.
  // ---------------------------------------------------------------
  localparam logic [7:0] DCC_OFF_CONTROL = 8'h00;  // Channel control register.
  localparam logic [7:0] DCC_OFF_SRC_SIZE = 8'h04;  // Source block size in bytes.
  localparam logic [7:0] DCC_OFF_SRC_PTR = 8'h08;  // Read-only source pointer.
  localparam logic [7:0] DCC_OFF_PATTERN = 8'h0C;  // Pattern data and pattern enable.

  // ---------------------------------------------------------------
  // Field positions of the channel control register.
  // ---------------------------------------------------------------
  localparam int DCC_IGN_LSB = 24;  // Ignore value occupies 31 down to 24.
  localparam int DCC_BUSY_BIT = 15;  // Channel activity flag.
  localparam int DCC_IGNEN_BIT = 13;  // Ignore byte enable.
  localparam int DCC_PATLEN_BIT = 11;  // Pattern length select.
  localparam int DCC_CHNS_BIT = 8;  // Chain direction select.
  localparam int DCC_EN_BIT = 7;  // Channel enable.
  localparam int DCC_AED_BIT = 6;  // Events when disabled.
  localparam int DCC_CHN_BIT = 5;  // Chain enable.
  localparam int DCC_AUTO_BIT = 4;  // Stay enabled after a block completes.
  localparam int DCC_EDET_BIT = 2;  // Start event detected flag.
  localparam int DCC_PRI_LSB = 0;  // Priority field occupies 1 down to 0.
  localparam int DCC_PATEN_BIT = 16;  // Pattern match enable inside the pattern register.

  // ---------------------------------------------------------------
  // Reset values and widths.
  // ---------------------------------------------------------------
  localparam logic [15:0] DCC_RST_SRC_SIZE = 16'h0000;  // Zero stands for a full 65,536-byte block.
  localparam logic [15:0] DCC_RST_PATTERN = 16'h0000;  // Pattern data after reset.
  localparam logic [7:0] DCC_RST_IGNORE = 8'h00;  // Ignore value after reset.
  localparam logic [15:0] DCC_PTR_ONE = 16'h0001;  // Pointer increment per byte.

  // ---------------------------------------------------------------
  // Carrier types.
  // ---------------------------------------------------------------
  // One register port request, sampled at a rising edge.
  typedef struct packed {
    logic wr;  // Write strobe.
    logic rd;  // Read strobe.
    logic [7:0] addr;  // Byte address.
    logic [31:0] wdata;  // Write data.
  } dcc_reg_req_t;

  // One byte returned from the system bus.
  typedef struct packed {
    logic ack;  // Read transaction finished.
    logic [7:0] data;  // Byte read from the source.
  } dcc_bus_rsp_t;

  // Transfer engine states.
  typedef enum logic [0:0] {
    DCC_IDLE = 1'b0,  // No transaction on the bus.
    DCC_WAIT = 1'b1   // Read issued, waiting for its acknowledge.
  } dcc_state_t;

endpackage : dcc_pkg

// File: design/dcc_channel.sv
// Single DMA channel: control register, chaining, events, pattern termination and source pointer.
`timescale 1ns/1ps

module dcc_channel
  import dcc_pkg::*;
(
  input wire logic core_clk,  // Channel clock, 250 MHz.
  input wire logic nrst,  // Asynchronous reset, active low.
  input wire logic clk_en,  // Freezes all state while low.
  input wire dcc_reg_req_t reg_req,  // Register port request.
  output logic [31:0] rd_data,  // Read data, valid the cycle after a read.
  input wire logic start_evt,  // Start event, one byte per event.
  input wire logic abort_evt,  // Abort event.
  input wire logic done_lower,  // Block done pulse of the neighbour lower in priority.
  input wire logic done_higher,  // Block done pulse of the neighbour higher in priority.
  output logic bus_req,  // Source read request, held until acknowledge.
  output logic [15:0] bus_offset,  // Source byte offset of the request.
  input wire dcc_bus_rsp_t bus_rsp,  // Source read answer.
  output logic dst_valid,  // One-cycle pulse with a moved byte.
  output logic [7:0] dst_data,  // Moved byte.
  output logic block_done  // One-cycle pulse at block or pattern end.
);

  // ---------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------
  logic [7:0] ignore_value;  // Ignore byte value.
  logic pattern_ignore_enable;  // Ignore byte enable.
  logic pattern_length_select;  // High for a two-byte pattern.
  logic chain_direction_select;  // High chains to the lower neighbour.
  logic channel_enable_bit;  // Channel enable.
  logic events_when_disabled;  // Register events while disabled.
  logic chain_enable_bit;  // Chaining allowed.
  logic auto_enable_bit;  // Keep enabled after a block.
  logic event_detected_flag;  // A start event waits for service.
  logic [1:0] channel_priority_field;  // Priority, stored only.
  logic channel_activity_flag;  // Busy flag.
  logic [15:0] src_size;  // Block size in bytes.
  logic [15:0] pattern_data;  // Pattern bytes, first byte low.
  logic pattern_match_enable;  // Pattern termination on.
  logic [15:0] source_byte_pointer;  // Current source byte.
  logic [7:0] prev_byte;  // Last counted byte for a two-byte match.
  logic prev_valid;  // Last counted byte present.
  dcc_state_t state;  // Transfer engine state.

  // ---------------------------------------------------------------
  // Decode and next values.
  // ---------------------------------------------------------------
  logic wr_ctrl;  // Write to the control register.
  logic beat;  // A source byte arrives this cycle.
  logic byte_ignored;  // Arriving byte is a don't-care.
  logic pat_hit;  // Pattern detected on this byte.
  logic blk_end;  // Last byte of the block arrives.
  logic events_ok;  // Events are registered now.
  logic chain_fire;  // Selected neighbour enables this channel.
  logic next_en;  // Next channel enable.
  logic [15:0] next_ptr;  // Pointer after this byte.

  // Address match shared by write and read decode.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_ctrl = reg_req.wr && hit(reg_req.addr, DCC_OFF_CONTROL);
  assign beat = (state == DCC_WAIT) && bus_rsp.ack;
  assign next_ptr = source_byte_pointer + DCC_PTR_ONE;
  assign blk_end = beat && (next_ptr == src_size);
  assign events_ok = channel_enable_bit || events_when_disabled;
  // The direction bit is looked at only under chain enable.
  assign chain_fire = chain_enable_bit &&
                      (chain_direction_select ? done_lower : done_higher);
  // With the ignore enable set, a byte equal to the ignore value is skipped by the comparator.
  assign byte_ignored = pattern_ignore_enable && (bus_rsp.data == ignore_value);

  // Pattern comparator for one or two bytes.
  always_comb begin
    pat_hit = 1'b0;
    if (beat && pattern_match_enable && !byte_ignored) begin
      if (pattern_length_select) begin
        pat_hit = prev_valid && (prev_byte == pattern_data[7:0]) && (bus_rsp.data == pattern_data[15:8]);
      end else begin
        pat_hit = (bus_rsp.data == pattern_data[7:0]);
      end
    end
  end

  // Enable: software write, then hardware clear at the end or abort, then chain set.
  always_comb begin
    next_en = channel_enable_bit;
    if (wr_ctrl) begin
      next_en = reg_req.wdata[DCC_EN_BIT];
    end
    if ((abort_evt && events_ok) || ((blk_end || pat_hit) && !auto_enable_bit)) begin
      next_en = 1'b0;
    end
    if (chain_fire) begin
      next_en = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control register fields.
  // ---------------------------------------------------------------
  // Writable fields; unimplemented positions have no storage at all.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ignore_value <= DCC_RST_IGNORE;
      pattern_ignore_enable <= 1'b0;
      pattern_length_select <= 1'b0;
      chain_direction_select <= 1'b0;
      events_when_disabled <= 1'b0;
      chain_enable_bit <= 1'b0;
      auto_enable_bit <= 1'b0;
      channel_priority_field <= 2'h0;
    end else if (clk_en && wr_ctrl) begin
      ignore_value <= reg_req.wdata[DCC_IGN_LSB +: 8];
      pattern_ignore_enable <= reg_req.wdata[DCC_IGNEN_BIT];
      pattern_length_select <= reg_req.wdata[DCC_PATLEN_BIT];
      chain_direction_select <= reg_req.wdata[DCC_CHNS_BIT];
      events_when_disabled <= reg_req.wdata[DCC_AED_BIT];
      chain_enable_bit <= reg_req.wdata[DCC_CHN_BIT];
      auto_enable_bit <= reg_req.wdata[DCC_AUTO_BIT];
      channel_priority_field <= reg_req.wdata[DCC_PRI_LSB +: 2];
    end
  end

  // Enable and the activity flag; the flag holds while a read is still in flight.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      channel_enable_bit <= 1'b0;
      channel_activity_flag <= 1'b0;
    end else if (clk_en) begin
      channel_enable_bit <= next_en;
      channel_activity_flag <= next_en || (state == DCC_WAIT && !bus_rsp.ack) ||
                               (state == DCC_IDLE && channel_enable_bit && event_detected_flag);
    end
  end

  // Start event flag; a new event wins over the clear when service begins.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      event_detected_flag <= 1'b0;
    end else if (clk_en) begin
      if (start_evt && events_ok) begin
        event_detected_flag <= 1'b1;
      end else if ((abort_evt && events_ok) || (state == DCC_IDLE && channel_enable_bit && event_detected_flag)) begin
        event_detected_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Size and pattern registers.
  // ---------------------------------------------------------------
  // Software writes block size, pattern bytes and the pattern enable.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_size <= DCC_RST_SRC_SIZE;
      pattern_data <= DCC_RST_PATTERN;
      pattern_match_enable <= 1'b0;
    end else if (clk_en && reg_req.wr) begin
      if (hit(reg_req.addr, DCC_OFF_SRC_SIZE)) begin
        src_size <= reg_req.wdata[15:0];
      end else if (hit(reg_req.addr, DCC_OFF_PATTERN)) begin
        pattern_data <= reg_req.wdata[15:0];
        pattern_match_enable <= reg_req.wdata[DCC_PATEN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Transfer engine.
  // ---------------------------------------------------------------
  // One read per serviced start event; a suspend lets the read finish.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= DCC_IDLE;
      bus_req <= 1'b0;
    end else if (clk_en) begin
      case (state)
        DCC_IDLE: begin
          if (channel_enable_bit && event_detected_flag) begin
            state <= DCC_WAIT;
            bus_req <= 1'b1;
          end
        end
        DCC_WAIT: begin
          if (bus_rsp.ack) begin
            state <= DCC_IDLE;
            bus_req <= 1'b0;
          end
        end
        default: begin
          state <= DCC_IDLE;
          bus_req <= 1'b0;
        end
      endcase
    end
  end

  // Source pointer: steps per byte, returns to zero at block end, abort or pattern detect.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      source_byte_pointer <= 16'h0000;
    end else if (clk_en) begin
      if (pat_hit || blk_end || (abort_evt && events_ok)) begin
        source_byte_pointer <= 16'h0000;
      end else if (beat) begin
        source_byte_pointer <= next_ptr;
      end
    end
  end

  // Pattern history of the last counted byte; ignored bytes leave it alone.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_byte <= 8'h00;
      prev_valid <= 1'b0;
    end else if (clk_en) begin
      if (pat_hit || blk_end || (abort_evt && events_ok)) begin
        prev_valid <= 1'b0;
      end else if (beat && !byte_ignored) begin
        prev_byte <= bus_rsp.data;
        prev_valid <= 1'b1;
      end
    end
  end

  // Outputs toward the source bus, the destination and the neighbours.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_offset <= 16'h0000;
      dst_valid <= 1'b0;
      dst_data <= 8'h00;
      block_done <= 1'b0;
    end else if (clk_en) begin
      bus_offset <= source_byte_pointer;
      dst_valid <= beat;
      dst_data <= bus_rsp.data;
      block_done <= blk_end || pat_hit;
    end
  end

  // ---------------------------------------------------------------
  // Read data.
  // ---------------------------------------------------------------
  // Unmapped addresses and unimplemented bits read zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h00000000;
    end else if (clk_en) begin
      rd_data <= 32'h00000000;
      if (reg_req.rd) begin
        if (hit(reg_req.addr, DCC_OFF_CONTROL)) begin
          rd_data[DCC_IGN_LSB +: 8] <= ignore_value;
          rd_data[DCC_BUSY_BIT] <= channel_activity_flag;
          rd_data[DCC_IGNEN_BIT] <= pattern_ignore_enable;
          rd_data[DCC_PATLEN_BIT] <= pattern_length_select;
          rd_data[DCC_CHNS_BIT] <= chain_direction_select;
          rd_data[DCC_EN_BIT] <= channel_enable_bit;
          rd_data[DCC_AED_BIT] <= events_when_disabled;
          rd_data[DCC_CHN_BIT] <= chain_enable_bit;
          rd_data[DCC_AUTO_BIT] <= auto_enable_bit;
          rd_data[DCC_EDET_BIT] <= event_detected_flag;
          rd_data[DCC_PRI_LSB +: 2] <= channel_priority_field;
        end else if (hit(reg_req.addr, DCC_OFF_SRC_SIZE)) begin
          rd_data[15:0] <= src_size;
        end else if (hit(reg_req.addr, DCC_OFF_SRC_PTR)) begin
          rd_data[15:0] <= source_byte_pointer;
        end else if (hit(reg_req.addr, DCC_OFF_PATTERN)) begin
          rd_data[15:0] <= pattern_data;
          rd_data[DCC_PATEN_BIT] <= pattern_match_enable;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  // A read that is in flight while software has cleared the enable.
  sequence s_suspend_in_flight;
    clk_en && !channel_enable_bit && state == DCC_WAIT && !bus_rsp.ack;
  endsequence

  a_ctrl_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && reg_req.rd && reg_req.addr == DCC_OFF_CONTROL |=> rd_data[23:16] == 8'h00 && !rd_data[14]
      && !rd_data[12] && rd_data[10:9] == 2'h0 && !rd_data[3]) else $error("control reserved bits not zero");

  a_sptr_read_value: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && reg_req.rd && reg_req.addr == DCC_OFF_SRC_PTR |=> rd_data == {16'h0000, $past(source_byte_pointer)})
    else $error("source pointer read wrong");
  a_busy_when_enabled: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && next_en |=> channel_activity_flag) else $error("activity flag low while enabled");
  a_suspend_drain: assert property (@(posedge core_clk) disable iff (!nrst)
    s_suspend_in_flight |=> channel_activity_flag && bus_req) else $error("suspend dropped a transaction");
  a_idle_drops_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && !next_en && (state == DCC_WAIT ? bus_rsp.ack : !(channel_enable_bit && event_detected_flag))
    |=> !channel_activity_flag) else $error("activity flag stuck high");
  a_chain_gated: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && !channel_enable_bit && !chain_enable_bit && !wr_ctrl |=> !channel_enable_bit)
    else $error("channel enabled without chaining");
  a_chain_direction: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && chain_enable_bit && chain_direction_select && done_lower |=> channel_enable_bit)
    else $error("lower neighbour did not enable channel");
  a_enable_write: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && wr_ctrl && !reg_req.wdata[DCC_EN_BIT] && !chain_fire |=> !channel_enable_bit)
    else $error("enable clear not taken");
  a_events_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && !channel_enable_bit && !events_when_disabled && !event_detected_flag |=> !event_detected_flag)
    else $error("event registered while disabled");

  a_pattern_reset: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && pat_hit |=> source_byte_pointer == 16'h0000 && block_done) else $error("pointer not reset on detect");

  a_ignore_skip: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && beat && pattern_ignore_enable && bus_rsp.data == ignore_value |-> !pat_hit ##1 !block_done || $past(blk_end))
    else $error("ignored byte took part in match");

  a_single_byte_match: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && beat && pattern_match_enable && !pattern_length_select && !byte_ignored
      && bus_rsp.data == pattern_data[7:0] |=> block_done && source_byte_pointer == 16'h0000)
    else $error("single byte pattern missed");

endmodule : dcc_channel

// File: testbench/dcc_bus_model.sv
// System bus source memory model that answers one byte read at a time.
`timescale 1ns/1ps
module dcc_bus_model
  import dcc_pkg::*;
(
  input wire logic core_clk,  // Bus clock.
  input wire logic nrst,  // Asynchronous reset, active low.
  input wire logic [3:0] delay,  // Wait cycles before each acknowledge.
  input wire logic bus_req,  // Read request from the channel.
  input wire logic [15:0] bus_offset,  // Source byte offset.
  output dcc_bus_rsp_t bus_rsp  // Acknowledge and byte.
);
  logic [3:0] cnt;  // Cycles waited on the current request.
  logic done;  // Request answered, waiting for it to drop.
  // Source byte is 30h plus the offset; between answers the data lines toggle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      done <= 1'b0;
      bus_rsp <= '0;
    end else if (bus_rsp.ack) begin
      bus_rsp.ack <= 1'b0;
      bus_rsp.data <= ~bus_rsp.data;
      done <= 1'b1;
    end else if (bus_req && !done && cnt == delay) begin
      bus_rsp.ack <= 1'b1;
      bus_rsp.data <= 8'h30 + bus_offset[7:0];
    end else begin
      cnt <= (bus_req && !done) ? cnt + 4'h1 : 4'h0;
      done <= done && bus_req;
      bus_rsp.data <= ~bus_rsp.data;
    end
  end
endmodule : dcc_bus_model

// File: testbench/dma_channel_control_tb.sv
// Self-checking bench for the DMA channel control block.
`timescale 1ns/1ps
module dma_channel_control_tb
  import dcc_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  dcc_reg_req_t reg_req = '0;
  logic start_evt = 1'b0;
  logic abort_evt = 1'b0;
  logic clk_en = 1'b1;  // Clock enable, lowered once to check the freeze.
  logic done_lower = 1'b0;
  logic done_higher = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [31:0] rd_data;
  logic bus_req;
  logic [15:0] bus_offset;
  dcc_bus_rsp_t bus_rsp;
  logic dst_valid;
  logic [7:0] dst_data;
  logic block_done;
  logic [31:0] got;  // Last register read.
  logic d;  // Block end seen after a byte.
  logic seen_done;  // Block end flag from the monitor.
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int moved = 0;
  int m0;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} dcc_row_t;
  typedef struct {logic [31:0] ctl; logic [31:0] pat; int n;} dcc_pat_t;
  typedef struct {logic [31:0] ctl; logic lo; logic hi; logic [31:0] e;} dcc_chn_t;
  dcc_row_t rows [7] = '{'{8'h00, 32'hFFFFFFFF, 32'hFF00A9F3}, '{8'h00, 32'h12342A55, 32'h12002851},
    '{8'h04, 32'h1234ABCD, 32'h0000ABCD}, '{8'h08, 32'h0000FFFF, 32'h00000000},
    '{8'h0C, 32'hFFFFFFFF, 32'h0001FFFF}, '{8'h10, 32'hFFFFFFFF, 32'h00000000}, '{8'h00, 32'h0, 32'h0}};
  dcc_pat_t pats [4] = '{'{32'h80, 32'h10032, 3}, '{32'h880, 32'h13231, 3},
    '{32'h31002880, 32'h13230, 3}, '{32'h31000880, 32'h13230, 0}};
  dcc_chn_t chns [5] = '{'{32'h20, 1'b1, 1'b0, 32'h20}, '{32'h20, 1'b0, 1'b1, 32'h80A0},
    '{32'h120, 1'b0, 1'b1, 32'h120}, '{32'h120, 1'b1, 1'b0, 32'h81A0}, '{32'h100, 1'b1, 1'b1, 32'h100}};

  dcc_channel DUT (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_req(reg_req), .rd_data(rd_data),
    .start_evt(start_evt), .abort_evt(abort_evt), .done_lower(done_lower), .done_higher(done_higher),
    .bus_req(bus_req), .bus_offset(bus_offset), .bus_rsp(bus_rsp), .dst_valid(dst_valid),
    .dst_data(dst_data), .block_done(block_done));
  dcc_bus_model u_bus (.core_clk(core_clk), .nrst(nrst), .delay(delay), .bus_req(bus_req),
    .bus_offset(bus_offset), .bus_rsp(bus_rsp));

  always #2 core_clk = ~core_clk;

  // Monitor: counts moved bytes, notes block ends and cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (dst_valid === 1'b1) moved++;
    if (block_done === 1'b1) seen_done = 1'b1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // Compares one value and reports a mismatch.
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One-cycle register write.
  task wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge core_clk);
    reg_req <= {1'b1, 1'b0, a, w};
    @(posedge core_clk);
    reg_req <= '0;
  endtask : wr

  // One-cycle register read; data taken in the following cycle.
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_req <= {1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk);
    reg_req <= '0;
    #1 got = rd_data;
  endtask : rd

  task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, got);
  endtask : rchk

  // Pulses a start event and waits for the moved byte.
  task move(input logic [7:0] e, output logic dn);
    @(posedge core_clk);
    start_evt <= 1'b1;
    @(posedge core_clk);
    start_evt <= 1'b0;
    seen_done = 1'b0;
    for (int i = 0; i < 30 && dst_valid !== 1'b1; i++) @(negedge core_clk);
    chk("dst_valid", 1'b1, dst_valid);
    chk("dst_data", e, dst_data);
    repeat (2) @(negedge core_clk);
    dn = seen_done;
  endtask : move

  // Aborts through events-when-disabled, clearing the pointer.
  task abort_all();
    wr(8'h00, 32'h40);
    @(posedge core_clk);
    abort_evt <= 1'b1;
    @(posedge core_clk);
    abort_evt <= 1'b0;
  endtask : abort_all

  task test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Main sequence.
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(DCC_OFF_CONTROL, 32'h0, "reset control");
    rchk(DCC_OFF_SRC_SIZE, {16'h0, DCC_RST_SRC_SIZE}, "reset size");
    rchk(DCC_OFF_SRC_PTR, 32'h0, "reset pointer");
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].e, $sformatf("row %0d", i));
    end
    $display("register table done");
    m0 = moved;
    @(posedge core_clk);
    start_evt <= 1'b1;
    @(posedge core_clk);
    start_evt <= 1'b0;
    rchk(8'h00, 32'h0, "start ignored");
    wr(8'h00, 32'h40);
    @(posedge core_clk);
    start_evt <= 1'b1;
    @(posedge core_clk);
    start_evt <= 1'b0;
    rchk(8'h00, 32'h44, "start registered");
    @(posedge core_clk);
    abort_evt <= 1'b1;
    @(posedge core_clk);
    abort_evt <= 1'b0;
    rchk(8'h00, 32'h40, "abort registered");
    chk("no move", m0, moved);
    $display("event test done");
    delay <= 4'h3;
    wr(DCC_OFF_PATTERN, 32'h0);
    wr(DCC_OFF_SRC_SIZE, 32'h4);
    wr(8'h00, 32'h80);
    for (int k = 0; k < 4; k++) begin
      move(8'h30 + k[7:0], d);
      chk("block end", k == 3, d);
      if (k == 1) rchk(DCC_OFF_SRC_PTR, 32'h2, "pointer");
    end
    rchk(8'h00, 32'h0, "idle after block");
    $display("transfer test done");
    delay <= 4'h0;
    wr(DCC_OFF_SRC_SIZE, 32'h10);
    foreach (pats[i]) begin
      abort_all();
      wr(DCC_OFF_PATTERN, pats[i].pat);
      wr(8'h00, pats[i].ctl);
      for (int k = 0; k < 4; k++) begin
        move(8'h30 + k[7:0], d);
        chk($sformatf("pattern %0d", i), k + 1 == pats[i].n, d);
        if (k + 1 == pats[i].n) break;
      end
      if (pats[i].n != 0) begin
        rchk(DCC_OFF_SRC_PTR, 32'h0, "pointer at match");
        rchk(8'h00, pats[i].ctl & 32'hFFFFFF7F, "control at match");
      end
    end
    $display("pattern test done");
    foreach (chns[i]) begin
      wr(8'h00, chns[i].ctl);
      @(posedge core_clk);
      done_lower <= chns[i].lo;
      done_higher <= chns[i].hi;
      @(posedge core_clk);
      done_lower <= 1'b0;
      done_higher <= 1'b0;
      rchk(8'h00, chns[i].e, $sformatf("chain %0d", i));
    end
    $display("chain test done");
    abort_all();
    delay <= 4'h8;
    wr(8'h00, 32'h80);
    m0 = moved;
    @(posedge core_clk);
    start_evt <= 1'b1;
    @(posedge core_clk);
    start_evt <= 1'b0;
    for (int i = 0; i < 10 && bus_req !== 1'b1; i++) @(negedge core_clk);
    chk("bus_offset", 32'h0, {16'h0, bus_offset});
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk("busy in flight", 1'b1, got[15]);
    for (int i = 0; i < 20 && got[15] !== 1'b0; i++) rd(8'h00);
    chk("busy dropped", 1'b0, got[15]);
    chk("in-flight byte", m0 + 1, moved);
    $display("suspend test done");
    // A write while the clock enable is low must leave the control register untouched.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h00, 32'h80);
    clk_en <= 1'b1;
    rchk(8'h00, 32'h0, "clock enable hold");
    $display("clock enable test done");
    test_done();
  end
endmodule : dma_channel_control_tb
